// File: shared/msg_pkg.sv
// package for the motor supply guard and brake sequencer
// assumes a 100 MHz system clock and a synchronous active-low reset
package msg_pkg;
  // object dictionary indices and subindices
  localparam logic [15:0] IDX_UPPER_V   = 16'h2034;
  localparam logic [15:0] IDX_LOWER_V   = 16'h2035;
  localparam logic [15:0] IDX_IDLE_TIME = 16'h2036;
  localparam logic [15:0] IDX_RED_VALUE = 16'h2037;
  localparam logic [15:0] IDX_BRAKE     = 16'h2038;
  localparam logic [15:0] IDX_CURRENTS  = 16'h2039;
  localparam logic [7:0]  SUB_COUNT     = 8'h00;
  localparam logic [7:0]  SUB_CLOSE_DLY = 8'h01;
  localparam logic [7:0]  SUB_OFF_DLY   = 8'h02;
  localparam logic [7:0]  SUB_OPEN_DLY  = 8'h03;
  localparam logic [7:0]  SUB_START_DLY = 8'h04;
  localparam logic [7:0]  SUB_PWM_FREQ  = 8'h05;
  localparam logic [7:0]  SUB_PWM_DUTY  = 8'h06;
  localparam logic [31:0] BRAKE_ENTRIES = 32'h0000_0006;
  localparam logic [31:0] CURR_ENTRIES  = 32'h0000_0004;
  // values after reset
  localparam logic [31:0] RST_UPPER_V   = 32'h0000_DA5A;
  localparam logic [31:0] RST_LOWER_V   = 32'h0000_2710;
  localparam logic [31:0] RST_IDLE_TIME = 32'h0000_03E8;
  localparam logic [31:0] RST_RED_VALUE = 32'h0FFF_FFCE;
  localparam logic [31:0] RST_CLOSE_DLY = 32'h0000_03E8;
  localparam logic [31:0] RST_OFF_DLY   = 32'h0000_03E8;
  localparam logic [31:0] RST_OPEN_DLY  = 32'h0000_03E8;
  localparam logic [31:0] RST_START_DLY = 32'h0000_0000;
  localparam logic [31:0] RST_PWM       = 32'h0000_0000;
  // supply hysteresis in millivolts
  localparam logic [31:0] OV_HYST_MV    = 32'd2000;
  localparam logic [31:0] UV_HYST_MV    = 32'd1500;
  // brake pwm limits
  localparam logic [31:0] PWM_FREQ_MAX  = 32'd2000;
  localparam logic [31:0] PWM_DUTY_MIN  = 32'd2;
  localparam logic [31:0] PWM_DUTY_MAX  = 32'd100;
  localparam logic [6:0]  PWM_SLOTS     = 7'd100;
  // current reduction
  localparam int          OPEN_LOOP_BIT = 3;
  localparam logic [31:0] PCT_BASE      = 32'd100;
  localparam logic [31:0] PCT_MIN       = 32'hFFFF_FF9C;
  // peak = rms * sqrt(2), as a fixed point factor
  localparam logic [15:0] SQRT2_NUM     = 16'd23170;
  localparam int          SQRT2_SHIFT   = 14;
  // time base
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam logic [31:0] CLK_HZ        = 32'(1000000000 / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    ST_OFF, ST_RELEASE, ST_START, ST_RUN, ST_CLOSE, ST_POWEROFF
  } msg_seq_e;
endpackage : msg_pkg

// File: src/msg_supply_brake.sv
// supply supervision, standstill current reduction, brake sequencing and brake pwm
// assumes all inputs come from logic on ref_clk_i; dictionary port is single-cycle
//
// Overview of operation
// - supply above upper threshold: motor off, overvoltage
// - overvoltage clears below upper minus 2 V
// - supply below lower threshold: motor off, undervoltage
// - undervoltage clears above lower plus 1.5 V
// - reduction starts after programmed idle milliseconds
// - reduction only open loop and at standstill
// - non-negative value below rated is milliamperes
// - -1..-100 scales rated current by percent
// - brake delays counted in milliseconds
// - standstill, close-brake delay, then brake engages
// - brake engaged, power-off delay, then current off
// - current on, release delay, then brake opens
// - brake open, start delay, then operation enabled
// - pwm frequency follows setting, 0 to 2000 Hz
// - pwm duty follows setting, 0 or 2..100
// - currents reported as peak, rms times root two
`timescale 1ns/1ps
module msg_supply_brake
  import msg_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               od_req_i,
  input  wire logic               od_wr_i,
  input  wire logic [15:0]        od_index_i,
  input  wire logic [7:0]         od_sub_i,
  input  wire logic [31:0]        od_wdata_i,
  output logic                    od_ack_o,
  output logic                    od_err_o,
  output logic [31:0]             od_rdata_o,
  input  wire logic [31:0]        supply_mv_i,
  input  wire logic [31:0]        drive_cfg_i,
  input  wire logic [31:0]        rated_ma_i,
  input  wire logic               motor_moving_i,
  input  wire logic               power_req_i,
  input  wire logic signed [31:0] i_d_rms_i,
  input  wire logic signed [31:0] i_q_rms_i,
  input  wire logic signed [31:0] i_a_rms_i,
  input  wire logic signed [31:0] i_b_rms_i,
  output logic                    motor_on_o,
  output logic                    brake_open_o,
  output logic                    brake_pwm_o,
  output logic                    op_enabled_o,
  output logic                    overvolt_o,
  output logic                    undervolt_o,
  output logic                    reduce_on_o,
  output logic [31:0]             current_set_o
);

  // settings
  logic [31:0] upper_reg, upper_next, lower_reg, lower_next;
  logic [31:0] idle_reg, idle_next, red_reg, red_next;
  logic [31:0] dly_reg [4];
  logic [31:0] dly_next [4];
  logic [31:0] freq_reg, freq_next, duty_reg, duty_next;
  logic        ack_next, err_next;
  logic [31:0] rdata_next;
  logic signed [31:0] peak_reg [4];

  always_comb begin
    upper_next = upper_reg;
    lower_next = lower_reg;
    idle_next  = idle_reg;
    red_next   = red_reg;
    dly_next   = dly_reg;
    freq_next  = freq_reg;
    duty_next  = duty_reg;
    ack_next   = od_req_i;
    err_next   = 1'b0;
    rdata_next = 32'h0000_0000;
    if (od_req_i) begin
      unique case (od_index_i)
        IDX_UPPER_V: begin
          rdata_next = upper_reg;
          if (od_wr_i) upper_next = od_wdata_i;
        end
        IDX_LOWER_V: begin
          rdata_next = lower_reg;
          if (od_wr_i) lower_next = od_wdata_i;
        end
        IDX_IDLE_TIME: begin
          rdata_next = idle_reg;
          if (od_wr_i) idle_next = od_wdata_i;
        end
        IDX_RED_VALUE: begin
          rdata_next = red_reg;
          if (od_wr_i) red_next = od_wdata_i;
        end
        IDX_BRAKE: begin
          unique case (od_sub_i)
            SUB_COUNT: begin
              rdata_next = BRAKE_ENTRIES;
              err_next   = od_wr_i;
            end
            SUB_CLOSE_DLY, SUB_OFF_DLY, SUB_OPEN_DLY, SUB_START_DLY: begin
              rdata_next = dly_reg[od_sub_i[1:0] - 2'd1];
              if (od_wr_i) dly_next[od_sub_i[1:0] - 2'd1] = od_wdata_i;
            end
            SUB_PWM_FREQ: begin
              rdata_next = freq_reg;
              if (od_wr_i && od_wdata_i > PWM_FREQ_MAX) err_next = 1'b1;
              else if (od_wr_i) freq_next = od_wdata_i;
            end
            SUB_PWM_DUTY: begin
              rdata_next = duty_reg;
              if (od_wr_i && ((od_wdata_i != 32'h0 && od_wdata_i < PWM_DUTY_MIN)
                              || od_wdata_i > PWM_DUTY_MAX)) err_next = 1'b1;
              else if (od_wr_i) duty_next = od_wdata_i;
            end
            default: err_next = 1'b1;
          endcase
        end
        IDX_CURRENTS: begin
          // read only object; writes answer with an error
          err_next = od_wr_i || od_sub_i > 8'h04;
          if (od_sub_i == SUB_COUNT) rdata_next = CURR_ENTRIES;
          else if (od_sub_i <= 8'h04) rdata_next = peak_reg[od_sub_i[1:0] - 2'd1];
        end
        default: err_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      upper_reg  <= RST_UPPER_V;
      lower_reg  <= RST_LOWER_V;
      idle_reg   <= RST_IDLE_TIME;
      red_reg    <= RST_RED_VALUE;
      dly_reg[0] <= RST_CLOSE_DLY;
      dly_reg[1] <= RST_OFF_DLY;
      dly_reg[2] <= RST_OPEN_DLY;
      dly_reg[3] <= RST_START_DLY;
      freq_reg   <= RST_PWM;
      duty_reg   <= RST_PWM;
      od_ack_o   <= 1'b0;
      od_err_o   <= 1'b0;
      od_rdata_o <= 32'h0000_0000;
    end else begin
      upper_reg  <= upper_next;
      lower_reg  <= lower_next;
      idle_reg   <= idle_next;
      red_reg    <= red_next;
      dly_reg    <= dly_next;
      freq_reg   <= freq_next;
      duty_reg   <= duty_next;
      od_ack_o   <= ack_next;
      od_err_o   <= err_next;
      od_rdata_o <= rdata_next;
    end
  end

  // peak currents, one multiplier per channel
  logic signed [31:0] rms_w [4];
  assign rms_w[0] = i_d_rms_i;
  assign rms_w[1] = i_q_rms_i;
  assign rms_w[2] = i_a_rms_i;
  assign rms_w[3] = i_b_rms_i;
  for (genvar g = 0; g < 4; g++) begin : g_peak
    logic signed [48:0] prod_w;
    assign prod_w = 49'(rms_w[g]) * $signed({1'b0, SQRT2_NUM});
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) peak_reg[g] <= 32'sh0000_0000;
      else peak_reg[g] <= 32'(prod_w >>> SQRT2_SHIFT);
    end
  end

  // supply supervision; a set always wins over the self-clear
  logic ov_next, uv_next;
  always_comb begin
    ov_next = overvolt_o;
    uv_next = undervolt_o;
    if (supply_mv_i < upper_reg - OV_HYST_MV) ov_next = 1'b0;
    if (supply_mv_i > upper_reg) ov_next = 1'b1;
    if (supply_mv_i > lower_reg + UV_HYST_MV) uv_next = 1'b0;
    if (supply_mv_i < lower_reg) uv_next = 1'b1;
  end

  // brake sequencer with its own millisecond prescaler, restarted on each step
  msg_seq_e    st_reg, st_next;
  logic [31:0] seq_pre_reg, seq_pre_next, seq_ms_reg, seq_ms_next;
  logic        fault_w, seq_tick_w, motor_next, brake_next, op_next;
  assign fault_w    = ov_next || uv_next;
  assign seq_tick_w = seq_pre_reg == 32'(MS_CYC - 1);
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_OFF:      if (power_req_i) st_next = ST_RELEASE;
      ST_RELEASE:  if (seq_ms_reg >= dly_reg[2]) st_next = ST_START;
      ST_START:    if (seq_ms_reg >= dly_reg[3]) st_next = ST_RUN;
      ST_RUN:      if (!power_req_i && !motor_moving_i) st_next = ST_CLOSE;
      ST_CLOSE:    if (seq_ms_reg >= dly_reg[0]) st_next = ST_POWEROFF;
      ST_POWEROFF: if (seq_ms_reg >= dly_reg[1]) st_next = ST_OFF;
    endcase
    // supply errors drop the motor at once, no brake grace time
    if (fault_w) st_next = ST_OFF;
    seq_pre_next = (st_next != st_reg || seq_tick_w) ? 32'h0 : seq_pre_reg + 32'h1;
    if (st_next != st_reg) seq_ms_next = 32'h0;
    else if (seq_tick_w && seq_ms_reg != 32'hFFFF_FFFF) seq_ms_next = seq_ms_reg + 32'h1;
    else seq_ms_next = seq_ms_reg;
    motor_next = st_next != ST_OFF;
    brake_next = st_next inside {ST_START, ST_RUN, ST_CLOSE};
    op_next    = st_next == ST_RUN;
  end

  // standstill idle timer and current reduction
  logic [31:0] idle_pre_reg, idle_pre_next, idle_ms_reg, idle_ms_next;
  logic        reduce_next;
  logic [6:0]  pct_w;
  logic [38:0] scaled_w;
  logic [31:0] cur_next;
  always_comb begin
    idle_pre_next = (motor_moving_i || idle_pre_reg == 32'(MS_CYC - 1)) ? 32'h0
                    : idle_pre_reg + 32'h1;
    if (motor_moving_i) idle_ms_next = 32'h0;
    else if (idle_pre_reg == 32'(MS_CYC - 1) && idle_ms_reg != 32'hFFFF_FFFF)
      idle_ms_next = idle_ms_reg + 32'h1;
    else idle_ms_next = idle_ms_reg;
    reduce_next = drive_cfg_i[OPEN_LOOP_BIT] && !motor_moving_i
                  && idle_ms_reg >= idle_reg;
    pct_w    = 7'(red_reg + PCT_BASE);
    scaled_w = 39'(rated_ma_i) * 39'(pct_w);
    cur_next = rated_ma_i;
    if (reduce_next) begin
      if (!red_reg[31] && red_reg < rated_ma_i) cur_next = red_reg;
      else if (red_reg[31] && red_reg >= PCT_MIN)
        cur_next = 32'(scaled_w / 39'(PCT_BASE));
    end
  end

  // brake pwm: 100 duty slots stepped at freq*100 by a phase accumulator
  logic [31:0] acc_reg, acc_next, acc_sum_w;
  logic [6:0]  slot_reg, slot_next;
  logic        pwm_next;
  always_comb begin
    acc_sum_w = acc_reg + 32'(freq_reg * PCT_BASE);
    acc_next  = acc_sum_w;
    slot_next = slot_reg;
    if (acc_sum_w >= CLK_HZ) begin
      acc_next  = acc_sum_w - CLK_HZ;
      slot_next = (slot_reg == PWM_SLOTS - 7'd1) ? 7'd0 : slot_reg + 7'd1;
    end
    // zero frequency or zero duty leaves the brake coil fully driven
    if (freq_reg == 32'h0 || duty_reg == 32'h0) pwm_next = brake_next;
    else pwm_next = brake_next && 32'(slot_reg) < duty_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_reg        <= ST_OFF;
      seq_pre_reg   <= 32'h0;
      seq_ms_reg    <= 32'h0;
      idle_pre_reg  <= 32'h0;
      idle_ms_reg   <= 32'h0;
      acc_reg       <= 32'h0;
      slot_reg      <= 7'h0;
      motor_on_o    <= 1'b0;
      brake_open_o  <= 1'b0;
      op_enabled_o  <= 1'b0;
      brake_pwm_o   <= 1'b0;
      overvolt_o    <= 1'b0;
      undervolt_o   <= 1'b0;
      reduce_on_o   <= 1'b0;
      current_set_o <= 32'h0;
    end else begin
      st_reg        <= st_next;
      seq_pre_reg   <= seq_pre_next;
      seq_ms_reg    <= seq_ms_next;
      idle_pre_reg  <= idle_pre_next;
      idle_ms_reg   <= idle_ms_next;
      acc_reg       <= acc_next;
      slot_reg      <= slot_next;
      motor_on_o    <= motor_next;
      brake_open_o  <= brake_next;
      op_enabled_o  <= op_next;
      brake_pwm_o   <= pwm_next;
      overvolt_o    <= ov_next;
      undervolt_o   <= uv_next;
      reduce_on_o   <= reduce_next;
      current_set_o <= cur_next;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_bad_freq;
    od_req_i && od_wr_i && od_index_i == IDX_BRAKE && od_sub_i == SUB_PWM_FREQ
      && od_wdata_i > PWM_FREQ_MAX;
  endsequence
  // the start delay itself is counted in ms, too long to unroll here
  sequence s_open_then_run;
    $rose(brake_open_o) ##1 brake_open_o;
  endsequence

  a_ov_set: assert property (supply_mv_i > upper_reg |=> overvolt_o)
    else $error("overvoltage not raised");
  a_ov_clear: assert property (overvolt_o && supply_mv_i < upper_reg - OV_HYST_MV
    |=> !overvolt_o)
    else $error("overvoltage did not clear");
  a_uv_set: assert property (supply_mv_i < lower_reg |=> undervolt_o)
    else $error("undervoltage not raised");
  a_uv_clear: assert property (undervolt_o && supply_mv_i > lower_reg + UV_HYST_MV
    |=> !undervolt_o)
    else $error("undervoltage did not clear");
  a_fault_motor_off: assert property ((overvolt_o || undervolt_o) |-> !motor_on_o)
    else $error("motor on during supply error");
  a_reduce_gate: assert property (reduce_on_o
    |-> $past(drive_cfg_i[OPEN_LOOP_BIT]) && !$past(motor_moving_i))
    else $error("reduction outside open-loop standstill");
  a_brake_after_motor: assert property ($rose(brake_open_o) |-> $past(motor_on_o, 1)
    && motor_on_o)
    else $error("brake opened without motor current");
  a_run_after_brake: assert property ($rose(op_enabled_o) |-> brake_open_o
    && $past(brake_open_o))
    else $error("operation enabled before brake open");
  a_off_brake_closed: assert property ($fell(motor_on_o) |-> !brake_open_o)
    else $error("motor off with brake open");
  a_freq_reject: assert property (s_bad_freq |=> od_err_o && $stable(freq_reg))
    else $error("bad pwm frequency accepted");
  a_pwm_idle: assert property (!brake_open_o |-> !brake_pwm_o)
    else $error("pwm active with brake closed");
  a_open_not_run: assert property (s_open_then_run |-> !op_enabled_o)
    else $error("operation enabled together with brake release");

endmodule : msg_supply_brake

// File: dv/msg_plant_model.sv
// plant model: supply source, motor shaft and phase currents seen by the guard
// assumes the bench sets the supply target and motion command at the falling edge
`timescale 1ns/1ps
module msg_plant_model (
  input  wire logic               move_cmd_i,
  input  wire logic [31:0]        supply_set_i,
  input  wire logic               motor_on_i,
  input  wire logic [31:0]        current_set_i,
  output logic [31:0]             supply_mv_o,
  output logic                    moving_o,
  output logic signed [31:0]      i_d_o,
  output logic signed [31:0]      i_q_o,
  output logic signed [31:0]      i_a_o,
  output logic signed [31:0]      i_b_o
);
  // an unpowered winding carries no current, so readings drop to zero with the drive
  assign supply_mv_o = supply_set_i;
  assign moving_o    = move_cmd_i;
  assign i_a_o       = motor_on_i ? $signed(current_set_i) : 32'sh0;
  assign i_b_o       = -i_a_o;
  assign i_d_o       = i_a_o >>> 1;
  assign i_q_o       = -i_d_o;
endmodule : msg_plant_model

// File: dv/motor_supply_guard_brake_seq_test.sv
// self-checking bench for supply guard, current reduction, brake sequencing and pwm
// assumes msg_pkg and the plant model are compiled first; inputs move at the falling edge
`timescale 1ns/1ps
module motor_supply_guard_brake_seq_test;
  import msg_pkg::*;
  localparam int          MSC   = 10;
  localparam logic [31:0] RATED = 32'd4200;
  localparam int MON = 0, BRK = 1, OPE = 2, RED = 3, OVV = 4, UNV = 5;
  logic               ref_clk_i, rst_b_i, od_req_i, od_wr_i, od_ack_o, od_err_o;
  logic [15:0]        od_index_i;
  logic [7:0]         od_sub_i;
  logic [31:0]        od_wdata_i, od_rdata_o, supply_set, supply_mv, drive_cfg, current_set;
  logic               moving, move_cmd, power_req, motor_on, brake_open, brake_pwm;
  logic               op_enabled, overvolt, undervolt, reduce_on;
  logic signed [31:0] i_d, i_q, i_a, i_b;
  logic [5:0]         outs;
  int                 num_errors, checks_done, cyc;
  assign outs = {undervolt, overvolt, reduce_on, op_enabled, brake_open, motor_on};

  msg_supply_brake #(.MS_CYC(MSC)) i_msg_supply_brake (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .od_req_i(od_req_i), .od_wr_i(od_wr_i),
    .od_index_i(od_index_i), .od_sub_i(od_sub_i), .od_wdata_i(od_wdata_i),
    .od_ack_o(od_ack_o), .od_err_o(od_err_o), .od_rdata_o(od_rdata_o),
    .supply_mv_i(supply_mv), .drive_cfg_i(drive_cfg), .rated_ma_i(RATED),
    .motor_moving_i(moving), .power_req_i(power_req), .i_d_rms_i(i_d), .i_q_rms_i(i_q),
    .i_a_rms_i(i_a), .i_b_rms_i(i_b), .motor_on_o(motor_on), .brake_open_o(brake_open),
    .brake_pwm_o(brake_pwm), .op_enabled_o(op_enabled), .overvolt_o(overvolt),
    .undervolt_o(undervolt), .reduce_on_o(reduce_on), .current_set_o(current_set));

  msg_plant_model i_msg_plant_model (
    .move_cmd_i(move_cmd), .supply_set_i(supply_set), .motor_on_i(motor_on),
    .current_set_i(current_set), .supply_mv_o(supply_mv), .moving_o(moving),
    .i_d_o(i_d), .i_q_o(i_q), .i_a_o(i_a), .i_b_o(i_b));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // whole run needs about four hundred cycles; the ceiling leaves ample slack
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 10000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  // one-cycle request pulse, answer looked for on the following cycles
  task automatic od_access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                           input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    @(negedge ref_clk_i);
    od_req_i   = 1'b1;
    od_wr_i    = wr;
    od_index_i = idx;
    od_sub_i   = sub;
    od_wdata_i = wd;
    @(negedge ref_clk_i);
    od_req_i = 1'b0;
    n = 0;
    while (od_ack_o !== 1'b1 && n < 3) begin
      @(negedge ref_clk_i);
      n++;
    end
    cmp_bit(od_ack_o, 1'b1, "dictionary answer");
    rd  = od_rdata_o;
    err = od_err_o;
  endtask : od_access

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic        err;
    od_access(1'b0, idx, sub, 32'h0, rd, err);
    cmp_bit(err, exp_err, "read refusal");
    if (!exp_err) cmp_word(rd, exp, "read data");
  endtask : rd_chk

  task automatic wr_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                        input logic exp_err);
    logic [31:0] rd;
    logic        err;
    od_access(1'b1, idx, sub, wd, rd, err);
    cmp_bit(err, exp_err, "write refusal");
  endtask : wr_chk

  // counts falling edges until the watched output reaches the level
  task automatic wait_out(input int sel, input logic lvl, input int lo, input int hi,
                          input string what);
    int n;
    n = 0;
    while (outs[sel] !== lvl && n <= hi) begin
      @(negedge ref_clk_i);
      n++;
    end
    cmp_bit(n >= lo && n <= hi, 1'b1, what);
  endtask : wait_out

  task automatic hold_out(input int sel, input logic lvl, input int cycles, input string what);
    repeat (cycles) begin
      @(negedge ref_clk_i);
      cmp_bit(outs[sel], lvl, what);
    end
  endtask : hold_out

  function automatic logic [31:0] peak(input logic signed [31:0] rms);
    logic signed [63:0] p;
    p = 64'(rms) * $signed({48'h0, SQRT2_NUM});
    return 32'(p >>> SQRT2_SHIFT);
  endfunction : peak

  task automatic t_reset_values();
    logic [31:0] dly [4];
    dly = '{RST_CLOSE_DLY, RST_OFF_DLY, RST_OPEN_DLY, RST_START_DLY};
    rd_chk(IDX_UPPER_V, SUB_COUNT, RST_UPPER_V, 1'b0);
    rd_chk(IDX_LOWER_V, SUB_COUNT, RST_LOWER_V, 1'b0);
    rd_chk(IDX_IDLE_TIME, SUB_COUNT, RST_IDLE_TIME, 1'b0);
    rd_chk(IDX_RED_VALUE, SUB_COUNT, RST_RED_VALUE, 1'b0);
    rd_chk(IDX_BRAKE, SUB_COUNT, BRAKE_ENTRIES, 1'b0);
    for (int s = 0; s < 4; s++) rd_chk(IDX_BRAKE, 8'(s + 1), dly[s], 1'b0);
    rd_chk(IDX_BRAKE, SUB_PWM_FREQ, RST_PWM, 1'b0);
    rd_chk(IDX_BRAKE, SUB_PWM_DUTY, RST_PWM, 1'b0);
    rd_chk(IDX_CURRENTS, SUB_COUNT, CURR_ENTRIES, 1'b0);
    rd_chk(IDX_CURRENTS, 8'h05, 32'h0, 1'b1);
    wr_chk(IDX_CURRENTS, 8'h01, 32'h5, 1'b1);
    wr_chk(IDX_BRAKE, SUB_COUNT, 32'h7, 1'b1);
    rd_chk(IDX_BRAKE, 8'h07, 32'h0, 1'b1);
    rd_chk(16'h2033, SUB_COUNT, 32'h0, 1'b1);
  endtask : t_reset_values

  task automatic t_brake_seq();
    logic signed [31:0] rms [4];
    rms = '{32'sd2100, -32'sd2100, 32'sd4200, -32'sd4200};
    wr_chk(IDX_BRAKE, SUB_CLOSE_DLY, 32'h2, 1'b0);
    wr_chk(IDX_BRAKE, SUB_OFF_DLY, 32'h3, 1'b0);
    wr_chk(IDX_BRAKE, SUB_OPEN_DLY, 32'h2, 1'b0);
    wr_chk(IDX_BRAKE, SUB_START_DLY, 32'h1, 1'b0);
    @(negedge ref_clk_i);
    power_req = 1'b1;
    wait_out(MON, 1'b1, 1, 2, "motor current on");
    wait_out(BRK, 1'b1, 2 * MSC - 1, 2 * MSC + 4, "brake opens");
    wait_out(OPE, 1'b1, MSC - 1, MSC + 4, "operation enabled");
    cmp_bit(brake_pwm, 1'b1, "steady brake drive");
    for (int s = 0; s < 4; s++) rd_chk(IDX_CURRENTS, 8'(s + 1), peak(rms[s]), 1'b0);
    power_req = 1'b0;
    wait_out(OPE, 1'b0, 1, 2, "operation left");
    wait_out(BRK, 1'b0, 2 * MSC - 1, 2 * MSC + 4, "brake closes");
    wait_out(MON, 1'b0, 3 * MSC - 1, 3 * MSC + 4, "motor current off");
  endtask : t_brake_seq

  task automatic t_pwm_limits();
    wr_chk(IDX_BRAKE, SUB_PWM_FREQ, PWM_FREQ_MAX, 1'b0);
    wr_chk(IDX_BRAKE, SUB_PWM_FREQ, 32'd2001, 1'b1);
    rd_chk(IDX_BRAKE, SUB_PWM_FREQ, PWM_FREQ_MAX, 1'b0);
    wr_chk(IDX_BRAKE, SUB_PWM_DUTY, 32'd1, 1'b1);
    wr_chk(IDX_BRAKE, SUB_PWM_DUTY, PWM_DUTY_MIN, 1'b0);
    wr_chk(IDX_BRAKE, SUB_PWM_DUTY, 32'd101, 1'b1);
    rd_chk(IDX_BRAKE, SUB_PWM_DUTY, PWM_DUTY_MIN, 1'b0);
    wr_chk(IDX_BRAKE, SUB_PWM_DUTY, PWM_DUTY_MAX, 1'b0);
  endtask : t_pwm_limits

  task automatic t_supply();
    wr_chk(IDX_UPPER_V, SUB_COUNT, 32'h0000_C350, 1'b0);
    @(negedge ref_clk_i);
    power_req = 1'b1;
    wait_out(OPE, 1'b1, 3 * MSC, 3 * MSC + 12, "running again");
    hold_out(OPE, 1'b1, 1, "running");
    // full duty keeps every slot driven while the brake is open
    cmp_bit(brake_pwm, 1'b1, "full duty drive");
    supply_set = 32'h0000_C351;
    wait_out(OVV, 1'b1, 1, 2, "overvoltage raised");
    wait_out(MON, 1'b0, 0, 2, "motor cut on overvoltage");
    supply_set = 32'h0000_BB80;
    hold_out(OVV, 1'b1, 5, "overvoltage inside hysteresis");
    hold_out(MON, 1'b0, 20, "motor held off");
    power_req  = 1'b0;
    supply_set = 32'h0000_BB7F;
    wait_out(OVV, 1'b0, 1, 2, "overvoltage cleared");
    supply_set = 32'h0000_270F;
    wait_out(UNV, 1'b1, 1, 2, "undervoltage raised");
    power_req = 1'b1;
    hold_out(MON, 1'b0, 10, "motor held off low supply");
    power_req  = 1'b0;
    supply_set = 32'h0000_2CEC;
    hold_out(UNV, 1'b1, 5, "undervoltage inside hysteresis");
    supply_set = 32'h0000_2CED;
    wait_out(UNV, 1'b0, 1, 2, "undervoltage cleared");
  endtask : t_supply

  task automatic t_reduction();
    wr_chk(IDX_IDLE_TIME, SUB_COUNT, 32'h3, 1'b0);
    wr_chk(IDX_RED_VALUE, SUB_COUNT, 32'hFFFF_FFC4, 1'b0);
    hold_out(RED, 1'b0, 40, "no reduction closed loop");
    drive_cfg = 32'h0000_0008;
    move_cmd  = 1'b1;
    hold_out(RED, 1'b0, 40, "no reduction while moving");
    move_cmd = 1'b0;
    wait_out(RED, 1'b1, 2 * MSC, 3 * MSC + 4, "reduction after idle");
    cmp_word(current_set, (RATED * 32'd40) / 32'd100, "percent setpoint");
    wr_chk(IDX_RED_VALUE, SUB_COUNT, 32'h0000_01F4, 1'b0);
    hold_out(RED, 1'b1, 2, "reduction kept");
    cmp_word(current_set, 32'h0000_01F4, "absolute setpoint");
    wr_chk(IDX_RED_VALUE, SUB_COUNT, 32'hFFFF_FF9C, 1'b0);
    hold_out(RED, 1'b1, 2, "reduction kept");
    cmp_word(current_set, 32'h0, "full percent");
    wr_chk(IDX_RED_VALUE, SUB_COUNT, RATED, 1'b0);
    hold_out(RED, 1'b1, 2, "reduction kept");
    cmp_word(current_set, RATED, "value at rated");
    move_cmd = 1'b1;
    wait_out(RED, 1'b0, 1, 3, "reduction ends on motion");
  endtask : t_reduction

  initial begin
    {num_errors, checks_done, cyc} = '0;
    rst_b_i    = 1'b0;
    od_req_i   = 1'b0;
    od_wr_i    = 1'b0;
    od_index_i = 16'h0;
    od_sub_i   = 8'h0;
    od_wdata_i = 32'h0;
    supply_set = 32'h0000_5DC0;
    drive_cfg  = 32'h0;
    move_cmd   = 1'b0;
    power_req  = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    t_reset_values();
    t_brake_seq();
    t_pwm_limits();
    t_supply();
    t_reduction();
    end_sim();
  end
endmodule : motor_supply_guard_brake_seq_test
